// File: shared/tcp_pkg.sv
package tcp_pkg;

    // ==========================================================
    // Register map, byte addresses of aligned 32-bit words
    // ==========================================================
    localparam logic [7:0] OFS_COUNTER_CONTROL = 8'h00; // Wide counter control
    localparam logic [7:0] OFS_WIDE_LOW = 8'h04; // Wide counter bits 7:0
    localparam logic [7:0] OFS_WIDE_HIGH = 8'h08; // Wide counter bits 15:8
    localparam logic [7:0] OFS_IRQ_FLAGS = 8'h0C; // Peripheral flag register
    localparam logic [7:0] OFS_NARROW_TIMER = 8'h10; // Narrow timer count
    localparam logic [7:0] OFS_NARROW_PERIOD = 8'h14; // Narrow timer period
    localparam logic [7:0] OFS_UNIT_A_LOW = 8'h18; // Unit A value bits 7:0
    localparam logic [7:0] OFS_UNIT_A_HIGH = 8'h1C; // Unit A value bits 15:8
    localparam logic [7:0] OFS_UNIT_A_CONTROL = 8'h20; // Unit A mode
    localparam logic [7:0] OFS_UNIT_B_LOW = 8'h24; // Unit B value bits 7:0
    localparam logic [7:0] OFS_UNIT_B_HIGH = 8'h28; // Unit B value bits 15:8
    localparam logic [7:0] OFS_UNIT_B_CONTROL = 8'h2C; // Unit B mode
    localparam logic [7:0] OFS_UNIT_B_FLAG = 8'h30; // Unit B event flag
    localparam logic [7:0] OFS_NARROW_CONTROL = 8'h34; // Narrow timer enable

    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int unsigned CTRL_RUN = 0; // Wide counter runs
    localparam int unsigned CTRL_EXT_SRC = 1; // Count pin edges, not phase ticks
    localparam int unsigned CTRL_SYNC_BYPASS = 2; // Unsynchronised counting
    localparam int unsigned CTRL_XTAL_EN = 3; // Crystal amplifier on
    localparam int unsigned FLAG_CONV_DONE = 6;
    localparam int unsigned FLAG_SERIAL_DONE = 3;
    localparam int unsigned FLAG_CAPCOMP = 2;
    localparam int unsigned FLAG_PERIOD_MATCH = 1;
    localparam int unsigned FLAG_OVERFLOW = 0;

    // ==========================================================
    // Reset values and masks
    // ==========================================================
    localparam logic [7:0] RST_BYTE = 8'h00; // All registers clear at reset
    localparam logic [7:0] RST_FLAGS = 8'h00;
    localparam logic [7:0] FLAG_IMPL_MASK = 8'h4F; // Bits 7, 5, 4 absent
    localparam logic [7:0] CTRL_IMPL_MASK = 8'h0F;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [15:0] WIDE_ALL_ONES = 16'hFFFF;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int unsigned PHASE_DIV_CYCLES = 4; // pclk cycles per phase tick

    // ==========================================================
    // Unit modes
    // ==========================================================
    typedef enum logic [3:0] {
        CC_OFF = 4'h0,
        CC_CAP_FALL = 4'h4,
        CC_CAP_RISE = 4'h5,
        CC_CMP_SET = 4'h8,
        CC_CMP_CLEAR = 4'h9,
        CC_CMP_FLAG = 4'hA,
        CC_CMP_SPECIAL = 4'hB,
        CC_PWM = 4'hC
    } tcp_cc_mode_t;

    // Wide counter as seen by the units
    typedef struct packed {
        logic [15:0] count;
        logic valid; // Low in unsynchronised mode
    } tcp_tbase_t;

    // Narrow timer as seen by the units
    typedef struct packed {
        logic [7:0] count;
        logic reload; // One-cycle pulse on period match
    } tcp_ptbase_t;

    // Any of the compare modes
    function automatic logic is_compare(input logic [3:0] mode);
        return mode[3:2] == 2'b10;
    endfunction

    // Either capture mode
    function automatic logic is_capture(input logic [3:0] mode);
        return mode[3:1] == 3'b010;
    endfunction

endpackage

// File: src/tcp_capcomp.sv
module tcp_capcomp #(
    parameter bit START_CONV = 1'b0 // Special event also starts a conversion
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [3:0] mode,
    input wire logic wr_low,
    input wire logic wr_high,
    input wire logic [7:0] wdata,
    input wire logic cap_level,
    input wire tcp_pkg::tcp_tbase_t tbase,
    input wire tcp_pkg::tcp_ptbase_t ptbase,
    output logic [15:0] value_q,
    output logic event_pulse,
    output logic counter_clear,
    output logic conv_start,
    output logic out_q
);

    // ==========================================================
    // Capture and compare against the wide counter
    // ==========================================================
    logic cap_prev_q; // Previous sampled capture pin
    logic eq_q; // Match seen last cycle
    logic [7:0] duty_q; // Duty latched at each period start
    logic cap_edge;
    logic cap_hit;
    logic eq;
    logic cmp_hit;
    logic pwm;
    logic out_d;
    logic [15:0] value_d;

    // Pin already passed two flops in the top
    assign cap_edge = (mode[0] ? cap_level & ~cap_prev_q : ~cap_level & cap_prev_q);
    // Capture and compare need the synchronised time base
    assign cap_hit = tbase.valid & tcp_pkg::is_capture(mode) & cap_edge;
    assign eq = tbase.valid & tcp_pkg::is_compare(mode) & (tbase.count == value_q);
    // One hit per match, not one per cycle the match lasts
    assign cmp_hit = eq & ~eq_q;
    // PWM mode never raises the event
    assign event_pulse = cap_hit | cmp_hit;
    // Special event clears the shared counter
    assign counter_clear = cmp_hit & (mode == tcp_pkg::CC_CMP_SPECIAL);
    // Only unit difference: conversion start
    assign conv_start = counter_clear & START_CONV;
    assign pwm = (mode[3:2] == 2'b11);

    // Capture wins over a software write
    assign value_d = cap_hit ? tbase.count :
        {wr_high ? wdata : value_q[15:8], wr_low ? wdata : value_q[7:0]};

    // Output pin: PWM off the narrow timer, compare drives set/clear
    assign out_d = pwm ? (ptbase.reload ? (value_q[7:0] != 8'h00) :
                          (ptbase.count == duty_q) ? 1'b0 : out_q) :
        (cmp_hit & (mode == tcp_pkg::CC_CMP_SET)) ? 1'b1 :
        (cmp_hit & (mode == tcp_pkg::CC_CMP_CLEAR)) ? 1'b0 :
        (mode == tcp_pkg::CC_OFF) ? 1'b0 : out_q;

    // Unit state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            value_q <= tcp_pkg::RST_WORD;
            cap_prev_q <= 1'b0;
            eq_q <= 1'b0;
            duty_q <= tcp_pkg::RST_BYTE;
            out_q <= 1'b0;
        end else begin
            value_q <= value_d;
            cap_prev_q <= cap_level;
            eq_q <= eq;
            // Duty takes effect at the period start
            duty_q <= ptbase.reload ? value_q[7:0] : duty_q;
            out_q <= out_d;
        end
    end

endmodule

// File: src/tcp_top.sv
// Function
// - Flags set regardless of any enable
// - Flag bits 7, 5, 4 read zero
// - Bit 6 sets on conversion done
// - Bit 3 sets on serial transfer done
// - Bit 2 sets on unit A capture or match
// - Bit 1 sets on narrow period match
// - Bit 0 sets on wide overflow
// - Bypass bit counts pin edges directly
// - Unsynchronised counter runs and flags in sleep
// - Unsynchronised counter is no time base
// - Byte reads of counter always valid
// - Control bit 3 enables crystal amplifier
// - Each unit holds 16-bit value, control
// - Capture/compare on wide, PWM on narrow
// - Units share base; special event clears
// - PWM units share period and update
// - Units identical except conversion start
module tcp_top #(
    parameter int unsigned ADDR_W = 8,
    parameter int unsigned PHASE_DIV = tcp_pkg::PHASE_DIV_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic crystal_osc_in,
    output logic crystal_osc_out,
    output logic crystal_osc_out_oe,
    input wire logic unit_a_pin_in,
    input wire logic unit_b_pin_in,
    output logic unit_a_pin_out,
    output logic unit_b_pin_out,
    input wire logic sleep_mode,
    input wire logic conversion_done,
    input wire logic sync_serial_done,
    output logic conversion_start,
    output logic [7:0] irq_flags_out
);

    // ==========================================================
    // Elaboration checks
    // ==========================================================
    if (ADDR_W < 8) begin : g_bad_addr
        $error("ADDR_W must be at least 8");
    end
    if (PHASE_DIV < 1 || PHASE_DIV > 255) begin : g_bad_div
        $error("PHASE_DIV must be 1 to 255");
    end

    // ==========================================================
    // Pin synchronisers
    // ==========================================================
    logic [1:0] xin_sync_q; // Crystal/clock pin, two stages
    logic xin_prev_q; // Third stage, for edge detect
    logic [1:0] pin_a_sync_q; // Unit A capture pin
    logic [1:0] pin_b_sync_q; // Unit B capture pin
    logic ext_edge;

    // Stage 2 and the third stage feed the edge detector
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xin_sync_q <= 2'b00;
            xin_prev_q <= 1'b0;
            pin_a_sync_q <= 2'b00;
            pin_b_sync_q <= 2'b00;
        end else begin
            xin_sync_q <= {xin_sync_q[0], crystal_osc_in};
            xin_prev_q <= xin_sync_q[1];
            pin_a_sync_q <= {pin_a_sync_q[0], unit_a_pin_in};
            pin_b_sync_q <= {pin_b_sync_q[0], unit_b_pin_in};
        end
    end

    // Rising edge of the external clock
    assign ext_edge = xin_sync_q[1] & ~xin_prev_q;

    // ==========================================================
    // Phase tick
    // ==========================================================
    logic [7:0] phase_cnt_q; // Stands in for the core's phase clocks
    logic phase_tick;

    assign phase_tick = (phase_cnt_q == 8'(PHASE_DIV - 1));

    // Free-running divider
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_cnt_q <= tcp_pkg::RST_BYTE;
        end else begin
            phase_cnt_q <= phase_tick ? 8'h00 : 8'(phase_cnt_q + 8'h01);
        end
    end

    // ==========================================================
    // APB decode
    // ==========================================================
    logic [7:0] a8; // Low address byte
    logic setup;
    logic wr;
    logic aligned;
    logic [7:0] wbyte;
    logic sel_ctrl, sel_wlo, sel_whi, sel_flags, sel_nt, sel_np;
    logic sel_alo, sel_ahi, sel_actl, sel_blo, sel_bhi, sel_bctl, sel_bflag, sel_nctl;
    logic hit;

    assign a8 = paddr[7:0];
    assign aligned = (paddr[1:0] == 2'b00) && ((paddr >> 8) == '0);
    assign setup = psel & ~penable;
    // Writes land only at the access edge; low lane carries the byte
    assign wr = psel & penable & pwrite & pstrb[0] & hit;
    assign wbyte = pwdata[7:0];
    assign sel_ctrl = aligned & (a8 == tcp_pkg::OFS_COUNTER_CONTROL);
    assign sel_wlo = aligned & (a8 == tcp_pkg::OFS_WIDE_LOW);
    assign sel_whi = aligned & (a8 == tcp_pkg::OFS_WIDE_HIGH);
    assign sel_flags = aligned & (a8 == tcp_pkg::OFS_IRQ_FLAGS);
    assign sel_nt = aligned & (a8 == tcp_pkg::OFS_NARROW_TIMER);
    assign sel_np = aligned & (a8 == tcp_pkg::OFS_NARROW_PERIOD);
    assign sel_alo = aligned & (a8 == tcp_pkg::OFS_UNIT_A_LOW);
    assign sel_ahi = aligned & (a8 == tcp_pkg::OFS_UNIT_A_HIGH);
    assign sel_actl = aligned & (a8 == tcp_pkg::OFS_UNIT_A_CONTROL);
    assign sel_blo = aligned & (a8 == tcp_pkg::OFS_UNIT_B_LOW);
    assign sel_bhi = aligned & (a8 == tcp_pkg::OFS_UNIT_B_HIGH);
    assign sel_bctl = aligned & (a8 == tcp_pkg::OFS_UNIT_B_CONTROL);
    assign sel_bflag = aligned & (a8 == tcp_pkg::OFS_UNIT_B_FLAG);
    assign sel_nctl = aligned & (a8 == tcp_pkg::OFS_NARROW_CONTROL);
    assign hit = sel_ctrl | sel_wlo | sel_whi | sel_flags | sel_nt | sel_np | sel_alo |
        sel_ahi | sel_actl | sel_blo | sel_bhi | sel_bctl | sel_bflag | sel_nctl;

    // ==========================================================
    // Control registers
    // ==========================================================
    logic [7:0] ctrl_q; // counter_control_reg
    logic [3:0] mode_a_q; // unit_a_control
    logic [3:0] mode_b_q; // unit B control
    logic [7:0] nperiod_q; // narrow_timer_period
    logic nrun_q; // Narrow timer enable

    // Software-written configuration
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= tcp_pkg::RST_BYTE;
            mode_a_q <= tcp_pkg::CC_OFF;
            mode_b_q <= tcp_pkg::CC_OFF;
            nperiod_q <= tcp_pkg::RST_BYTE;
            nrun_q <= 1'b0;
        end else begin
            ctrl_q <= (wr & sel_ctrl) ? (wbyte & tcp_pkg::CTRL_IMPL_MASK) : ctrl_q;
            mode_a_q <= (wr & sel_actl) ? wbyte[3:0] : mode_a_q;
            mode_b_q <= (wr & sel_bctl) ? wbyte[3:0] : mode_b_q;
            nperiod_q <= (wr & sel_np) ? wbyte : nperiod_q;
            nrun_q <= (wr & sel_nctl) ? wbyte[0] : nrun_q;
        end
    end

    // Crystal amplifier: inverting, driven only when enabled
    assign crystal_osc_out = ctrl_q[tcp_pkg::CTRL_XTAL_EN] & ~crystal_osc_in;
    assign crystal_osc_out_oe = ctrl_q[tcp_pkg::CTRL_XTAL_EN];

    // ==========================================================
    // Narrow timer
    // ==========================================================
    logic [7:0] ntimer_q; // narrow_timer
    logic period_match;
    tcp_pkg::tcp_ptbase_t ptbase;

    // Match on the tick after the count reaches the period, then restart
    assign period_match = nrun_q & phase_tick & ~sleep_mode & (ntimer_q == nperiod_q);
    assign ptbase = '{count: ntimer_q, reload: period_match};

    // Narrow count, software may overwrite
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ntimer_q <= tcp_pkg::RST_BYTE;
        end else if (wr & sel_nt) begin
            ntimer_q <= wbyte;
        end else if (period_match) begin
            ntimer_q <= 8'h00;
        end else if (nrun_q & phase_tick & ~sleep_mode) begin
            ntimer_q <= 8'(ntimer_q + 8'h01);
        end
    end

    // ==========================================================
    // Wide counter and the two units
    // ==========================================================
    logic [15:0] wide_q;
    logic overflow;
    logic clear_a, clear_b;
    logic event_a, event_b;
    logic [15:0] value_a, value_b;
    tcp_pkg::tcp_tbase_t tbase;

    // No time base while counting unsynchronised
    assign tbase = '{count: wide_q,
        valid: ~(ctrl_q[tcp_pkg::CTRL_EXT_SRC] & ctrl_q[tcp_pkg::CTRL_SYNC_BYPASS])};

    tcp_wide_counter u_wide (
        .pclk(pclk),
        .presetn(presetn),
        .run(ctrl_q[tcp_pkg::CTRL_RUN]),
        .ext_src(ctrl_q[tcp_pkg::CTRL_EXT_SRC]),
        .sync_bypass_bit(ctrl_q[tcp_pkg::CTRL_SYNC_BYPASS]),
        .sleep_mode(sleep_mode),
        .phase_tick(phase_tick),
        .ext_edge(ext_edge),
        .load_low(wr & sel_wlo),
        .load_high(wr & sel_whi),
        .load_data(wbyte),
        .clear(clear_a | clear_b),
        .count_q(wide_q),
        .overflow(overflow)
    );

    tcp_capcomp #(.START_CONV(1'b0)) u_unit_a (
        .pclk(pclk),
        .presetn(presetn),
        .mode(mode_a_q),
        .wr_low(wr & sel_alo),
        .wr_high(wr & sel_ahi),
        .wdata(wbyte),
        .cap_level(pin_a_sync_q[1]),
        .tbase(tbase),
        .ptbase(ptbase),
        .value_q(value_a),
        .event_pulse(event_a),
        .counter_clear(clear_a),
        .conv_start(),
        .out_q(unit_a_pin_out)
    );

    // Same module, same time bases: shared base, shared PWM period
    tcp_capcomp #(.START_CONV(1'b1)) u_unit_b (
        .pclk(pclk),
        .presetn(presetn),
        .mode(mode_b_q),
        .wr_low(wr & sel_blo),
        .wr_high(wr & sel_bhi),
        .wdata(wbyte),
        .cap_level(pin_b_sync_q[1]),
        .tbase(tbase),
        .ptbase(ptbase),
        .value_q(value_b),
        .event_pulse(event_b),
        .counter_clear(clear_b),
        .conv_start(conversion_start),
        .out_q(unit_b_pin_out)
    );

    // ==========================================================
    // Flags
    // ==========================================================
    logic [7:0] flags_q; // peripheral_irq_flags
    logic [7:0] flag_set;
    logic [7:0] flags_d;
    logic bflag_q; // Unit B event flag

    // No enable gates any set
    assign flag_set = ({7'h00, overflow} << tcp_pkg::FLAG_OVERFLOW) |
        ({7'h00, period_match} << tcp_pkg::FLAG_PERIOD_MATCH) |
        ({7'h00, event_a} << tcp_pkg::FLAG_CAPCOMP) |
        ({7'h00, sync_serial_done} << tcp_pkg::FLAG_SERIAL_DONE) |
        ({7'h00, conversion_done} << tcp_pkg::FLAG_CONV_DONE);
    // Set beats a same-cycle software clear; absent bits stay zero
    assign flags_d = (((wr & sel_flags) ? wbyte : flags_q) | flag_set) &
        tcp_pkg::FLAG_IMPL_MASK;
    assign irq_flags_out = flags_q;

    // Sticky flags, cleared only by software writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_q <= tcp_pkg::RST_FLAGS;
            bflag_q <= 1'b0;
        end else begin
            flags_q <= flags_d;
            bflag_q <= ((wr & sel_bflag) ? wbyte[0] : bflag_q) | event_b;
        end
    end

    // ==========================================================
    // APB read path
    // ==========================================================
    logic [7:0] rd_byte;
    logic [31:0] prdata_q;
    logic pslverr_q;

    // Counter bytes come from a pclk flop, so never torn
    assign rd_byte = ({8{sel_ctrl}} & ctrl_q) | ({8{sel_wlo}} & wide_q[7:0]) |
        ({8{sel_whi}} & wide_q[15:8]) | ({8{sel_flags}} & flags_q) |
        ({8{sel_nt}} & ntimer_q) | ({8{sel_np}} & nperiod_q) |
        ({8{sel_alo}} & value_a[7:0]) | ({8{sel_ahi}} & value_a[15:8]) |
        ({8{sel_actl}} & {4'h0, mode_a_q}) | ({8{sel_blo}} & value_b[7:0]) |
        ({8{sel_bhi}} & value_b[15:8]) | ({8{sel_bctl}} & {4'h0, mode_b_q}) |
        ({8{sel_bflag}} & {7'h00, bflag_q}) | ({8{sel_nctl}} & {7'h00, nrun_q});

    // Snapshot taken in the setup cycle, so no wait states are needed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (setup) begin
            prdata_q <= {24'h00_0000, rd_byte};
            pslverr_q <= ~hit;
        end
    end

    assign prdata = prdata_q;
    assign pready = psel & penable;
    assign pslverr = psel & penable & pslverr_q;

endmodule

// File: src/tcp_wide_counter.sv
module tcp_wide_counter (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic ext_src,
    input wire logic sync_bypass_bit,
    input wire logic sleep_mode,
    input wire logic phase_tick,
    input wire logic ext_edge,
    input wire logic load_low,
    input wire logic load_high,
    input wire logic [7:0] load_data,
    input wire logic clear,
    output logic [15:0] count_q,
    output logic overflow
);

    // ==========================================================
    // Increment source
    // ==========================================================
    logic pend_q; // Edge waiting for the next phase tick
    logic pend_d;
    logic sync_inc;
    logic inc_src;
    logic halted;
    logic inc;
    logic writing;
    logic [15:0] count_d;

    // Synchronised mode holds a pin edge until the phase tick
    assign sync_inc = phase_tick & (pend_q | ext_edge);
    assign pend_d = ext_src & ~sync_bypass_bit & ~phase_tick & (pend_q | ext_edge);
    // Bypass counts the pin edge at once
    assign inc_src = ext_src ? (sync_bypass_bit ? ext_edge : sync_inc) : phase_tick;
    // Sleep stops phase clocks; only the unsynchronised path survives
    assign halted = sleep_mode & ~(ext_src & sync_bypass_bit);
    assign inc = run & ~halted & inc_src;
    assign writing = load_low | load_high;

    // Clear beats writes; writes beat the increment
    assign count_d = clear ? tcp_pkg::RST_WORD :
        writing ? {load_high ? load_data : count_q[15:8],
                   load_low ? load_data : count_q[7:0]} :
        inc ? 16'(count_q + 16'h0001) : count_q; // Wraps to zero

    // Overflow on the wrapping increment only
    assign overflow = inc & ~clear & ~writing & (count_q == tcp_pkg::WIDE_ALL_ONES);

    // Counter and pending edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= tcp_pkg::RST_WORD;
            pend_q <= 1'b0;
        end else begin
            count_q <= count_d;
            pend_q <= pend_d;
        end
    end

endmodule

// File: tb/tb_tcp_top.sv
module tb_tcp_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, unit_a_pin_in, unit_b_pin_in, sleep_mode;
    logic conversion_done, sync_serial_done, src_en, crystal_osc_in, e, pready, pslverr;
    logic crystal_osc_out, crystal_osc_out_oe, unit_a_pin_out, unit_b_pin_out, conversion_start;
    logic [7:0] paddr, q, irq_flags_out;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    int num_errors, comparisons, cycles;
    tcp_top u_tcp_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .crystal_osc_in, .crystal_osc_out, .crystal_osc_out_oe,
        .unit_a_pin_in, .unit_b_pin_in, .unit_a_pin_out, .unit_b_pin_out, .sleep_mode,
        .conversion_done, .sync_serial_done, .conversion_start, .irq_flags_out);
    tcp_xtal_model u_tcp_xtal_model (.en(src_en), .xclk(crystal_osc_in));
    always #20 pclk = ~pclk;
    task automatic chk(input string n, input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s exp %h got %h", n, exp, got);
        end
    endtask
    // ==========
    // APB transfer, held until pready
    task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, 24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        {e, q} = {pslverr, prdata[7:0]};
        {psel, penable} <= 2'b00;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string n);
        xfer(a, 1'b0, 8'h00);
        chk(n, q, exp);
    endtask
    task automatic wait_flag(input int b);
        for (int i = 0; i < 400 && irq_flags_out[b] !== 1'b1; i++) @(posedge pclk);
    endtask
    task automatic summarize();
        if (num_errors == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Hang guard
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            summarize();
        end
    end
    initial begin
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata, unit_a_pin_in} = '0;
        {unit_b_pin_in, sleep_mode, conversion_done, sync_serial_done, src_en} = '0;
        pstrb = 4'hF;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rd(8'h0C, 8'h00, "flags_reset");
        xfer(8'h0C, 1'b1, 8'hFF);
        rd(8'h0C, 8'h4F, "flags_ones");
        xfer(8'h0C, 1'b1, 8'h00);
        // Event pulses with no enable anywhere
        {conversion_done, sync_serial_done} <= 2'b11;
        @(posedge pclk);
        {conversion_done, sync_serial_done} <= 2'b00;
        repeat (3) @(posedge pclk);
        rd(8'h0C, 8'h48, "conv_serial");
        xfer(8'h0C, 1'b1, 8'h00);
        xfer(8'h14, 1'b1, 8'h03);
        xfer(8'h34, 1'b1, 8'h01);
        wait_flag(1);
        xfer(8'h34, 1'b1, 8'h00);
        rd(8'h0C, 8'h02, "period_match");
        xfer(8'h0C, 1'b1, 8'h00);
        xfer(8'h00, 1'b1, 8'h01);
        xfer(8'h20, 1'b1, 8'h05);
        unit_a_pin_in <= 1'b1;
        wait_flag(2);
        rd(8'h0C, 8'h04, "capture");
        // Unsynchronised mode, stopped, must not capture
        xfer(8'h00, 1'b1, 8'h06);
        xfer(8'h0C, 1'b1, 8'h00);
        unit_a_pin_in <= 1'b0;
        repeat (8) @(posedge pclk);
        unit_a_pin_in <= 1'b1;
        repeat (20) @(posedge pclk);
        rd(8'h0C, 8'h00, "async_no_capture");
        xfer(8'h04, 1'b1, 8'hFD);
        xfer(8'h08, 1'b1, 8'hFF);
        xfer(8'h00, 1'b1, 8'h0F);
        repeat (8) @(posedge pclk);
        sleep_mode <= 1'b1;
        src_en <= 1'b1;
        repeat (3) @(posedge crystal_osc_in);
        @(posedge pclk);
        src_en <= 1'b0;
        repeat (12) @(posedge pclk);
        sleep_mode <= 1'b0;
        rd(8'h08, 8'h00, "wide_high");
        rd(8'h04, 8'h00, "wide_low");
        rd(8'h08, 8'h00, "wide_high_again");
        rd(8'h0C, 8'h01, "overflow");
        xfer(8'h18, 1'b1, 8'hA5);
        rd(8'h18, 8'hA5, "unit_value");
        // Compare on unit A, special event on unit B
        xfer(8'h18, 1'b1, 8'h08);
        xfer(8'h20, 1'b1, 8'h08);
        xfer(8'h24, 1'b1, 8'h10);
        xfer(8'h2C, 1'b1, 8'h0B);
        xfer(8'h00, 1'b1, 8'h01);
        repeat (150) @(posedge pclk);
        rd(8'h0C, 8'h05, "compare_flags");
        rd(8'h30, 8'h01, "special_flag");
        chk("pin_a", {7'h00, unit_a_pin_out}, 8'h01);
        rd(8'h3C, 8'h00, "unmapped_data");
        chk("unmapped_err", {7'h00, e}, 8'h01);
        summarize();
    end
endmodule

// File: tb/tcp_asserts.sv
// ==========
// Flag register and crystal pin checks
module tcp_asserts #(
    parameter int unsigned ADDR_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic crystal_osc_in,
    input wire logic crystal_osc_out,
    input wire logic crystal_osc_out_oe,
    input wire logic conversion_done,
    input wire logic sync_serial_done,
    input wire logic [7:0] irq_flags_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // Committed writes, access edge only
    wire acc_wr = psel && penable && pwrite && pstrb[0];
    wire flag_wr = acc_wr && paddr == ADDR_W'(tcp_pkg::OFS_IRQ_FLAGS);
    wire ctrl_wr = acc_wr && paddr == ADDR_W'(tcp_pkg::OFS_COUNTER_CONTROL);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Setup cycle of a flag read
    sequence s_flag_setup;
        psel && !penable && !pwrite && paddr == ADDR_W'(tcp_pkg::OFS_IRQ_FLAGS);
    endsequence
    a_unimpl_zero: assert property ((irq_flags_out & 8'hB0) == 8'h00)
        else $error("unused flag bits set");
    a_conv_sets: assert property (conversion_done |=> irq_flags_out[6])
        else $error("conversion flag missed");
    a_serial_sets: assert property (sync_serial_done |=> irq_flags_out[3])
        else $error("serial flag missed");
    a_flags_sticky: assert property (!flag_wr |=>
        (irq_flags_out & $past(irq_flags_out)) == $past(irq_flags_out))
        else $error("flag cleared without software");
    a_osc_drive: assert property (crystal_osc_out == (crystal_osc_out_oe & !crystal_osc_in))
        else $error("crystal amplifier output wrong");
    a_oe_cause: assert property ($changed(crystal_osc_out_oe) |-> $past(ctrl_wr))
        else $error("amplifier enable moved alone");
    a_oe_value: assert property (ctrl_wr |=> crystal_osc_out_oe == $past(pwdata[3]))
        else $error("amplifier enable not written");
    a_flag_read: assert property (s_flag_setup ##1 (psel && penable) |->
        prdata == {24'h000000, $past(irq_flags_out)})
        else $error("flag read data wrong");
endmodule

bind tcp_top tcp_asserts #(.ADDR_W(ADDR_W)) u_tcp_asserts (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb, .prdata, .crystal_osc_in, .crystal_osc_out,
    .crystal_osc_out_oe, .conversion_done, .sync_serial_done, .irq_flags_out);

// File: tb/tcp_xtal_model.sv
// ==========
// External clock source, low while gated off
module tcp_xtal_model (
    input wire logic en,
    output logic xclk
);
    timeunit 1ns;
    timeprecision 1ps;
    initial xclk = 1'b0;
    always #160 xclk = en ? ~xclk : 1'b0;
endmodule
